// ---- common/fwsr_pkg.sv ----
// Constants and helpers shared by the flash status poller and its bus
// cycle engine.
// Assumes a 20 MHz system clock and an 8-bit parallel NOR flash.
package fwsr_pkg;

  // ==========================================================
  // Timing
  localparam int CLK_PERIOD_NS = 50;
  localparam int ACC_TIME_NS = 90;    // Read access time of the flash
  localparam int WE_PULSE_NS = 35;    // Least write pulse width
  localparam int SYNC_STAGES = 2;
  // Least times round up to whole cycles
  localparam int ACC_CYC = (ACC_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int WE_CYC = (WE_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // Output enable held long enough for access plus the synchroniser
  localparam int RD_HOLD_CYC = ACC_CYC + SYNC_STAGES;
  localparam int CNT_W = 3;
  localparam logic [CNT_W-1:0] RD_LOAD = CNT_W'(RD_HOLD_CYC - 1);
  localparam logic [CNT_W-1:0] WE_LOAD = CNT_W'(WE_CYC - 1);

  // ==========================================================
  // Widths
  localparam int AW = 23;
  localparam int DW = 8;
  localparam int RAW = 4;
  localparam int RDW = 32;

  // ==========================================================
  // Controller register map and fields
  localparam logic [RAW-1:0] REG_CTRL = 4'h0;
  localparam logic [RAW-1:0] REG_ADDR = 4'h1;
  localparam logic [RAW-1:0] REG_DATA = 4'h2;
  localparam logic [RAW-1:0] REG_STAT = 4'h3;
  localparam int CTRL_GO = 0;
  localparam int CTRL_DATA_METHOD = 1;
  localparam int CTRL_ABORT = 2;
  localparam int CTRL_WRITE = 3;
  localparam int STAT_BUSY = 0;
  localparam int STAT_DONE = 1;
  localparam int STAT_FAIL = 2;
  localparam int STAT_READY = 3;
  localparam int STAT_METHOD = 4;
  localparam int STAT_LAST_LSB = 8;
  localparam logic [AW-1:0] ADDR_RST = 23'h000000;
  localparam logic [DW-1:0] DATA_RST = 8'h00;

  // ==========================================================
  // Status bit positions on the flash data bus
  localparam int DQ_POLL = 7;
  localparam int DQ_TOGGLE = 6;
  localparam int DQ_LIMIT = 5;
  localparam int DQ_SECTOR = 2;
  localparam logic [DW-1:0] CMD_RESET = 8'hf0;

  // True when the toggle bit differs between two reads
  function automatic logic fwsr_toggled(input logic [DW-1:0] a,
                                        input logic [DW-1:0] b);
    return a[DQ_TOGGLE] ^ b[DQ_TOGGLE];
  endfunction

  // True when the polling bit shows the expected written value
  function automatic logic fwsr_poll_match(input logic [DW-1:0] rd,
                                           input logic [DW-1:0] exp);
    return rd[DQ_POLL] == exp[DQ_POLL];
  endfunction

endpackage

// ---- rtl/fwsr_bus_cycle.sv ----
// One read or write cycle on the flash pins, chip enable framed.
// Assumes the caller holds address and data steady while not ready.
`timescale 1ns/1ps
module fwsr_bus_cycle
  import fwsr_pkg::*;
(
  input wire logic clk_i,
  input wire logic srst_i,
  input wire logic req_i,
  input wire logic we_i,
  input wire logic [fwsr_pkg::AW-1:0] addr_i,
  input wire logic [fwsr_pkg::DW-1:0] wdata_i,
  output logic ready_o,
  output logic done_o,
  output logic [fwsr_pkg::DW-1:0] rdata_o,
  output logic [fwsr_pkg::AW-1:0] f_addr_o,
  output logic [fwsr_pkg::DW-1:0] f_dq_o,
  output logic f_dq_oe_n_o,
  input wire logic [fwsr_pkg::DW-1:0] f_dq_i,
  output logic f_ce_n_o,
  output logic f_oe_n_o,
  output logic f_we_n_o
);
  import fwsr_pkg::*;

  typedef enum logic [1:0] {CY_IDLE, CY_ACT, CY_REC} fwsr_cyc_e;

  fwsr_cyc_e st_q;
  logic [CNT_W-1:0] cnt_q;
  logic we_q;
  logic done_q;
  logic [DW-1:0] rdata_q;
  logic [DW-1:0] dq_s1_q;
  logic [DW-1:0] dq_s2_q;
  logic [AW-1:0] addr_q;
  logic [DW-1:0] wd_q;
  logic ce_n_q;
  logic oe_n_q;
  logic we_n_q;
  logic oe_dq_n_q;

  // ==========================================================
  // Handshake and pins
  assign ready_o = (st_q == CY_IDLE);
  assign done_o = done_q;
  assign rdata_o = rdata_q;
  assign f_addr_o = addr_q;
  assign f_dq_o = wd_q;
  assign f_dq_oe_n_o = oe_dq_n_q;
  assign f_ce_n_o = ce_n_q;
  assign f_oe_n_o = oe_n_q;
  assign f_we_n_o = we_n_q;

  // Data pins come from the flash, outside our timing
  always_ff @(posedge clk_i) begin
    dq_s1_q <= f_dq_i;
    dq_s2_q <= dq_s1_q;
  end

  // Cycle sequencer; data bus driven through the recovery cycle for hold
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      st_q <= CY_IDLE;
      cnt_q <= '0;
      we_q <= 1'b0;
      done_q <= 1'b0;
      rdata_q <= '0;
      addr_q <= '0;
      wd_q <= '0;
      ce_n_q <= 1'b1;
      oe_n_q <= 1'b1;
      we_n_q <= 1'b1;
      oe_dq_n_q <= 1'b1;
    end else begin
      done_q <= 1'b0;
      unique case (st_q)
        CY_IDLE: begin
          if (req_i) begin
            st_q <= CY_ACT;
            we_q <= we_i;
            addr_q <= addr_i;
            wd_q <= wdata_i;
            ce_n_q <= 1'b0;
            oe_n_q <= we_i;
            we_n_q <= ~we_i;
            oe_dq_n_q <= ~we_i;
            cnt_q <= we_i ? WE_LOAD : RD_LOAD;
          end
        end
        CY_ACT: begin
          if (cnt_q == '0) begin
            st_q <= CY_REC;
            ce_n_q <= 1'b1;
            oe_n_q <= 1'b1;
            we_n_q <= 1'b1;
            if (!we_q) begin
              rdata_q <= dq_s2_q;
            end
          end else begin
            cnt_q <= cnt_q - 1'b1;
          end
        end
        CY_REC: begin
          st_q <= CY_IDLE;
          oe_dq_n_q <= 1'b1;
          done_q <= 1'b1;
        end
      endcase
    end
  end

  // ==========================================================
  // Checks
  property p_oe_width;
    @(posedge clk_i) disable iff (srst_i)
    $fell(f_oe_n_o) |-> !f_oe_n_o [*4] ##1 f_oe_n_o;
  endproperty
  a_oe_width: assert property (p_oe_width)
    else $error("read strobe width wrong");

  property p_no_contention;
    @(posedge clk_i) disable iff (srst_i)
    !f_oe_n_o |-> f_dq_oe_n_o;
  endproperty
  a_no_contention: assert property (p_no_contention)
    else $error("data bus driven during read");

endmodule

// ---- rtl/fwsr_host.sv ----
// Host-side status poller for a parallel NOR flash running its internal
// program or erase algorithm. Software starts a poll or a raw write.
// Assumes flash pins are wired directly and the flash is the only target.
`timescale 1ns/1ps

module fwsr_host
  import fwsr_pkg::*;
(
  input wire logic CLK_I,
  input wire logic SRST_I,
  input wire logic [fwsr_pkg::RAW-1:0] ADDR_I,
  input wire logic [fwsr_pkg::RDW-1:0] WDATA_I,
  input wire logic WR_I,
  input wire logic RD_I,
  output logic [fwsr_pkg::RDW-1:0] RDATA_O,
  output logic [fwsr_pkg::AW-1:0] FLASH_ADDR_O,
  output logic [fwsr_pkg::DW-1:0] FLASH_DQ_O,
  output logic FLASH_DQ_OE_N_O,
  input wire logic [fwsr_pkg::DW-1:0] FLASH_DQ_I,
  output logic FLASH_CE_N_O,
  output logic FLASH_OE_N_O,
  output logic FLASH_WE_N_O,
  input wire logic READY_BUSY_N_PIN_I
);
  import fwsr_pkg::*;

  typedef enum logic [2:0] {
    S_IDLE, S_RD1, S_RD2, S_RD3, S_RST, S_WRITE
  } fwsr_state_e;

  fwsr_state_e st_q;
  fwsr_state_e st_d;
  logic [AW-1:0] addr_q;
  logic [DW-1:0] data_q;
  logic [DW-1:0] prev_q;
  logic [DW-1:0] last_q;
  logic method_q;
  logic waiting_q;
  logic done_q;
  logic fail_q;
  logic rb_s1_q;
  logic rb_s2_q;
  logic [RDW-1:0] rdata_q;

  logic cyc_req;
  logic cyc_we;
  logic [DW-1:0] cyc_wdata;
  logic cyc_ready;
  logic cyc_done;
  logic [DW-1:0] cyc_rdata;

  // ==========================================================
  // Register decode
  wire wr_ctrl = WR_I && (ADDR_I == REG_CTRL);
  wire wr_addr = WR_I && (ADDR_I == REG_ADDR);
  wire wr_data = WR_I && (ADDR_I == REG_DATA);
  wire go = wr_ctrl && WDATA_I[CTRL_GO];
  wire raw_wr = wr_ctrl && WDATA_I[CTRL_WRITE] && !WDATA_I[CTRL_GO];
  wire abort = wr_ctrl && WDATA_I[CTRL_ABORT];
  wire busy = (st_q != S_IDLE);
  wire [RDW-1:0] stat_word = {16'h0000, last_q, 3'b000, method_q,
                              rb_s2_q, fail_q, done_q, busy};
  wire [RDW-1:0] rd_mux = (ADDR_I == REG_CTRL) ? {31'h0, method_q} :
                          (ADDR_I == REG_ADDR) ? {9'h000, addr_q} :
                          (ADDR_I == REG_DATA) ? {24'h000000, data_q} :
                          (ADDR_I == REG_STAT) ? stat_word : '0;
  assign RDATA_O = rdata_q;

  // ==========================================================
  // Status decode of the read just finished
  wire rd_state = (st_q == S_RD1) || (st_q == S_RD2) || (st_q == S_RD3);
  wire step = cyc_done && waiting_q;
  wire toggled = fwsr_toggled(cyc_rdata, prev_q);
  wire matched = fwsr_poll_match(cyc_rdata, data_q);
  wire limit = cyc_rdata[DQ_LIMIT];
  wire rd3_ok = method_q ? matched : !toggled;
  wire finish_ok = step && (((st_q == S_RD1) && method_q && matched) ||
                            ((st_q == S_RD2) && !toggled) ||
                            ((st_q == S_RD3) && rd3_ok) ||
                            (st_q == S_WRITE));
  wire finish_bad = step && (st_q == S_RST);

  // ==========================================================
  // Cycle requests: poll reads always use the stored target address
  assign cyc_we = (st_q == S_RST) || (st_q == S_WRITE);
  assign cyc_req = (rd_state || cyc_we) && !waiting_q && cyc_ready;
  assign cyc_wdata = (st_q == S_RST) ? CMD_RESET : data_q;

  fwsr_bus_cycle i_fwsr_bus_cycle (
    .clk_i(CLK_I),
    .srst_i(SRST_I),
    .req_i(cyc_req),
    .we_i(cyc_we),
    .addr_i(addr_q),
    .wdata_i(cyc_wdata),
    .ready_o(cyc_ready),
    .done_o(cyc_done),
    .rdata_o(cyc_rdata),
    .f_addr_o(FLASH_ADDR_O),
    .f_dq_o(FLASH_DQ_O),
    .f_dq_oe_n_o(FLASH_DQ_OE_N_O),
    .f_dq_i(FLASH_DQ_I),
    .f_ce_n_o(FLASH_CE_N_O),
    .f_oe_n_o(FLASH_OE_N_O),
    .f_we_n_o(FLASH_WE_N_O)
  );

  // ==========================================================
  // Poll sequencer; a new start always re-enters the first read
  always_comb begin
    st_d = st_q;
    if (go) begin
      st_d = S_RD1;
    end else if (abort) begin
      st_d = S_IDLE;
    end else if (raw_wr && !busy) begin
      st_d = S_WRITE;
    end else if (step) begin
      unique case (st_q)
        S_RD1: begin
          if (!method_q) begin
            st_d = S_RD2;
          end else if (matched) begin
            st_d = S_IDLE;
          end else if (limit) begin
            st_d = S_RD3;
          end
        end
        S_RD2: begin
          if (!toggled) begin
            st_d = S_IDLE;
          end else if (limit) begin
            st_d = S_RD3;
          end
        end
        S_RD3: st_d = rd3_ok ? S_IDLE : S_RST;
        S_RST: st_d = S_IDLE;
        S_WRITE: st_d = S_IDLE;
        S_IDLE: st_d = S_IDLE;
      endcase
    end
  end

  // State and cycle tracking
  always_ff @(posedge CLK_I) begin
    if (SRST_I) begin
      st_q <= S_IDLE;
      waiting_q <= 1'b0;
      prev_q <= '0;
      last_q <= '0;
    end else begin
      st_q <= st_d;
      if (go || abort) begin
        waiting_q <= 1'b0;
      end else if (cyc_req) begin
        waiting_q <= 1'b1;
      end else if (cyc_done) begin
        waiting_q <= 1'b0;
      end
      if (step && rd_state) begin
        prev_q <= cyc_rdata;
        last_q <= cyc_rdata;
      end
    end
  end

  // Software registers; target is frozen while polling so reads stay valid
  always_ff @(posedge CLK_I) begin
    if (SRST_I) begin
      addr_q <= ADDR_RST;
      data_q <= DATA_RST;
      method_q <= 1'b0;
    end else begin
      if (wr_addr && !busy) begin
        addr_q <= WDATA_I[AW-1:0];
      end
      if (wr_data && !busy) begin
        data_q <= WDATA_I[DW-1:0];
      end
      if (go) begin
        method_q <= WDATA_I[CTRL_DATA_METHOD];
      end
    end
  end

  // Sticky outcome flags; a finish in the start cycle still sets
  always_ff @(posedge CLK_I) begin
    if (SRST_I) begin
      done_q <= 1'b0;
      fail_q <= 1'b0;
    end else begin
      done_q <= finish_ok | (done_q & ~go);
      fail_q <= finish_bad | (fail_q & ~go);
    end
  end

  // Ready/busy pin synchroniser and read port
  always_ff @(posedge CLK_I) begin
    if (SRST_I) begin
      rb_s1_q <= 1'b1;
      rb_s2_q <= 1'b1;
      rdata_q <= '0;
    end else begin
      rb_s1_q <= READY_BUSY_N_PIN_I;
      rb_s2_q <= rb_s1_q;
      rdata_q <= RD_I ? rd_mux : '0;
    end
  end

  // ==========================================================
  // Checks
  property p_poll_addr;
    @(posedge CLK_I) disable iff (SRST_I)
    cyc_req && !cyc_we |-> FLASH_CE_N_O ##1 FLASH_ADDR_O == addr_q;
  endproperty
  a_poll_addr: assert property (p_poll_addr)
    else $error("poll read not at target address");

  property p_addr_frozen;
    @(posedge CLK_I) disable iff (SRST_I)
    busy && !go |=> $stable(addr_q);
  endproperty
  a_addr_frozen: assert property (p_addr_frozen)
    else $error("target address moved during poll");

  property p_two_reads;
    @(posedge CLK_I) disable iff (SRST_I)
    st_q == S_RD1 && step && !method_q && !go && !abort |=> st_q == S_RD2;
  endproperty
  a_two_reads: assert property (p_two_reads)
    else $error("toggle poll ended after one read");

  property p_fail_reset;
    @(posedge CLK_I) disable iff (SRST_I)
    st_q == S_RD3 && step && !rd3_ok && !go && !abort
      |=> st_q == S_RST ##[1:20] (!FLASH_WE_N_O && FLASH_DQ_O == CMD_RESET);
  endproperty
  a_fail_reset: assert property (p_fail_reset)
    else $error("failed poll did not send reset");

  property p_restart;
    @(posedge CLK_I) disable iff (SRST_I)
    go |=> st_q == S_RD1 && !waiting_q;
  endproperty
  a_restart: assert property (p_restart)
    else $error("start did not restart polling");

  property p_recheck;
    @(posedge CLK_I) disable iff (SRST_I)
    st_q == S_RD1 && method_q && step && !matched && limit && !go && !abort
      |=> st_q == S_RD3;
  endproperty
  a_recheck: assert property (p_recheck)
    else $error("polling bit not rechecked after limit");

  c_toggle_ok: cover property (@(posedge CLK_I)
    st_q == S_RD2 && finish_ok);
  c_data_ok: cover property (@(posedge CLK_I)
    st_q == S_RD1 && finish_ok);
  c_fail: cover property (@(posedge CLK_I) finish_bad);

endmodule

// ---- tb/fwsr_flash_model.sv ----
// Behavioural NOR flash status model for the host poller bench.
// Assumes the bench arms an operation and resolves the shared data bus.
`timescale 1ns/1ps
module fwsr_flash_model
  import fwsr_pkg::*;
(
  input wire logic clk_i,
  input wire logic arm_i,
  input wire logic erase_i,
  input wire logic fail_i,
  input wire logic [3:0] reads_i,
  input wire logic [fwsr_pkg::DW-1:0] data_i,
  input wire logic ce_n_i,
  input wire logic oe_n_i,
  input wire logic we_n_i,
  input wire logic [fwsr_pkg::DW-1:0] dq_i,
  output logic [fwsr_pkg::DW-1:0] dq_o,
  output logic rb_n_o
);
  // ==========================================================
  // State
  logic busy_q = 1'b0;
  logic tog_q = 1'b0;
  logic tog2_q = 1'b0;
  logic oe_p_q = 1'b1;
  logic we_p_q = 1'b1;
  logic [3:0] cnt_q = 4'h0;
  logic [DW-1:0] last_q = 8'h00;
  logic [DW-1:0] stat_w;
  logic [DW-1:0] arr_w;
  logic rd_end_w;

  // ==========================================================
  // Status byte while busy
  // polling bit value
  assign stat_w = {erase_i ? 1'b0 : ~data_i[7], tog_q, fail_i, 2'b00,
                   erase_i ? tog2_q : data_i[2], data_i[1:0]};
  assign arr_w = erase_i ? 8'hff : data_i;
  assign rd_end_w = oe_n_i && !oe_p_q;
  // all bits switch together, strictest case for the host
  // Released bus shows inverse of last value, never a stale copy
  assign dq_o = (!oe_n_i && !ce_n_i) ? (busy_q ? stat_w : arr_w) : ~last_q;
  assign rb_n_o = ~busy_q;

  // Sampled edges; the host is clocked, so this is exact enough
  always @(posedge clk_i) begin
    oe_p_q <= oe_n_i;
    we_p_q <= we_n_i;
    if (!oe_n_i && !ce_n_i) begin
      last_q <= dq_o;
    end
    // short read count models brief burst
    if (arm_i) begin
      busy_q <= 1'b1;
      cnt_q <= reads_i;
    // toggling only while an algorithm runs
    end else if (rd_end_w && busy_q) begin
      tog_q <= ~tog_q;
      tog2_q <= ~tog2_q;
      cnt_q <= cnt_q - 4'h1;
      if (!fail_i && cnt_q <= 4'h1) begin
        busy_q <= 1'b0;
      end
    end
    // reset command ends a failed operation
    if (we_n_i && !we_p_q && dq_i === CMD_RESET) begin
      busy_q <= 1'b0;
    end
  end
endmodule

// ---- tb/test_fwsr_host.sv ----
// Self-checking bench for the flash status poller.
// Assumes the flash model answers on the far side of the pins.
`timescale 1ns/1ps
module test_fwsr_host;
  import fwsr_pkg::*;
  // ==========================================================
  // Signals
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic [RAW-1:0] addr = 4'h0;
  logic [RDW-1:0] wdata = 32'h0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [RDW-1:0] rdata;
  logic [AW-1:0] f_addr;
  logic [DW-1:0] f_dq_o, f_dq_i, m_dq;
  logic f_oe_dq_n, f_ce_n, f_oe_n, f_we_n, m_rb_n, rb_pin;
  logic arm = 1'b0, erase = 1'b0, fail = 1'b0;
  logic [3:0] reads = 4'h1;
  logic [DW-1:0] fdata = 8'h00;
  logic [AW-1:0] exp_addr = 23'h0;
  logic addr_chk = 1'b0;
  logic [31:0] seed = 32'h9be8;
  int err_total = 0;
  int cmp_count = 0;
  int cyc = 0;

  always #25 clk = ~clk;
  // Wire resolution: host drive wins, ready pin copies the model output
  assign f_dq_i = !f_oe_dq_n ? f_dq_o : m_dq;
  assign rb_pin = m_rb_n ? 1'b1 : 1'b0;

  fwsr_host i_fwsr_host (.CLK_I(clk), .SRST_I(srst), .ADDR_I(addr),
    .WDATA_I(wdata), .WR_I(wr), .RD_I(rd), .RDATA_O(rdata),
    .FLASH_ADDR_O(f_addr), .FLASH_DQ_O(f_dq_o),
    .FLASH_DQ_OE_N_O(f_oe_dq_n), .FLASH_DQ_I(f_dq_i),
    .FLASH_CE_N_O(f_ce_n), .FLASH_OE_N_O(f_oe_n), .FLASH_WE_N_O(f_we_n),
    .READY_BUSY_N_PIN_I(rb_pin));
  fwsr_flash_model i_fwsr_flash_model (.clk_i(clk), .arm_i(arm),
    .erase_i(erase), .fail_i(fail), .reads_i(reads), .data_i(fdata),
    .ce_n_i(f_ce_n), .oe_n_i(f_oe_n), .we_n_i(f_we_n), .dq_i(f_dq_i),
    .dq_o(m_dq), .rb_n_o(m_rb_n));

  // ==========================================================
  // Helpers
  function automatic logic [31:0] xs(input logic [31:0] x);
    x = x ^ (x << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction
  // Array content once the operation has ended
  function automatic logic [7:0] arr_of(input logic e, input logic [7:0] d);
    return e ? 8'hff : d;
  endfunction
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      err_total++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wreg(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rreg(input logic [3:0] a, output logic [31:0] d);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 d = rdata;
  endtask
  task automatic tally_and_finish;
    $display("Comparisons %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // Hang guard, well above the longest expected run
  always @(posedge clk) begin
    cyc++;
    if (cyc == 30000) begin
      err_total++;
      tally_and_finish;
    end
  end
  // every poll read sits at the target address
  always @(posedge clk) begin
    if (addr_chk && !f_oe_n) begin
      check(32'(f_addr), 32'(exp_addr));
    end
  end

  // ==========================================================
  // Main sequence
  initial begin
    logic [31:0] s;
    logic meth;
    int n;
    repeat (3) @(posedge clk);
    srst <= 1'b0;
    rreg(REG_STAT, s);
    check(s, 32'h8);
    rreg(4'h7, s);
    check(s, 32'h0);
    for (int i = 0; i < 16; i++) begin
      seed = xs(seed);
      meth = seed[1];
      @(posedge clk);
      erase <= seed[0];
      fail <= (i % 4 == 3);
      reads <= {1'b0, seed[4:2]} + 4'h1;
      fdata <= arr_of(seed[0], seed[15:8]);
      exp_addr <= seed[31:9];
      arm <= 1'b1;
      @(posedge clk);
      arm <= 1'b0;
      wreg(REG_ADDR, 32'(exp_addr));
      wreg(REG_DATA, 32'(fdata));
      addr_chk <= 1'b1;
      wreg(REG_CTRL, {30'h0, meth, 1'b1});
      rreg(REG_STAT, s);
      check({31'h0, s[STAT_BUSY]}, 32'h1);
      check({31'h0, s[STAT_READY]}, 32'h0);
      n = 0;
      while (s[STAT_BUSY] !== 1'b0 && n < 300) begin
        rreg(REG_STAT, s);
        n++;
      end
      addr_chk <= 1'b0;
      repeat (4) @(posedge clk);
      rreg(REG_STAT, s);
      check({31'h0, s[STAT_BUSY]}, 32'h0);
      check({31'h0, s[STAT_READY]}, 32'h1);
      check({31'h0, s[STAT_METHOD]}, {31'h0, meth});
      if (fail) begin
        check({31'h0, s[STAT_FAIL]}, 32'h1);
      end else begin
        check({31'h0, s[STAT_DONE]}, 32'h1);
        check({31'h0, s[STAT_FAIL]}, 32'h0);
        check({24'h0, s[15:8]}, {24'h0, fdata});
      end
    end
    // Corner: abort a poll of an operation that cannot end; writes refused while busy
    @(posedge clk);
    fail <= 1'b1;
    arm <= 1'b1;
    @(posedge clk);
    arm <= 1'b0;
    addr_chk <= 1'b1;
    wreg(REG_CTRL, 32'h3);
    rreg(REG_STAT, s);
    check({31'h0, s[STAT_BUSY]}, 32'h1);
    wreg(REG_ADDR, {9'h0, ~exp_addr});
    wreg(REG_CTRL, 32'h4);
    rreg(REG_STAT, s);
    check({29'h0, s[2:0]}, 32'h0);
    rreg(REG_ADDR, s);
    check(s, 32'(exp_addr));
    rreg(REG_CTRL, s);
    check(s, 32'h1);
    // Corner: raw write of the reset command frees the stuck flash
    wreg(REG_DATA, 32'(CMD_RESET));
    wreg(REG_CTRL, 32'h8);
    addr_chk <= 1'b0;
    repeat (8) @(posedge clk);
    check(32'(f_dq_o), 32'(CMD_RESET));
    check(32'(f_addr), 32'(exp_addr));
    check({31'h0, f_we_n}, 32'h1);
    check({31'h0, f_oe_dq_n}, 32'h1);
    rreg(REG_STAT, s);
    check({28'h0, s[3:0]}, 32'ha);
    rreg(REG_DATA, s);
    check(s, 32'(CMD_RESET));
    tally_and_finish;
  end
endmodule
